//--- hw/timer8_counter_compare.sv
`timescale 1ns/100ps
`default_nettype none
module timer8_counter_compare (
    input wire logic clk,
    input wire logic rstn,
    input wire timer8_pkg::av_req_s av_req,
    output logic [31:0] av_readdata,
    output logic av_waitrequest,
    input wire logic external_count_pin,
    output logic compare_output_a,
    output logic compare_output_b,
    output logic irq_overflow,
    output logic irq_compare_a,
    output logic irq_compare_b,
    output logic prescaler_clear
);
    import timer8_pkg::*;

    // whole state of the block
    typedef struct packed {
        logic [7:0] control_reg_a;
        logic [5:0] control_reg_b;     // wgm2 and clock select, force reads 0
        logic [7:0] counter_value;
        logic [7:0] compare_a_value;   // active
        logic [7:0] compare_b_value;
        logic [7:0] compare_a_buf;
        logic [7:0] compare_b_buf;
        logic [2:0] flags;
        logic [2:0] mask;
        logic sync_hold_mode;
        logic prescaler_sync_reset;
        logic timer_power_off;
        logic [presc_width-1:0] presc;
        logic block_match;             // counter written, no compare match on next tick
        logic count_down;              // phase correct direction
        logic [1:0] pin_sync;
        logic pin_last;
        logic oc_a;
        logic oc_b;
        logic [31:0] rdata;
        logic ack;                     // one cycle answer strobe
        logic [2:0] irq;
        logic psr_out;
    } state_s;

    state_s st;
    state_s next_st;

    // pwm modes buffer compare writes
    function automatic logic is_pwm(input logic [2:0] m);
        is_pwm = (m != mode_normal) && (m != mode_ctc) && (m != 3'h4) &&
            (m != 3'h6);
    endfunction

    // new output from compare action field
    function automatic logic apply_action(input logic [1:0] com,
        input logic cur);
        case (com)
            2'h1: apply_action = ~cur;
            2'h2: apply_action = 1'b0;
            2'h3: apply_action = 1'b1;
            // zero leaves the state alone
            default: apply_action = cur;
        endcase
    endfunction

    logic [2:0] mode;
    logic [7:0] top;
    logic tick;
    logic wr;
    logic rd;
    logic match_a;
    logic match_b;
    logic at_top;
    logic at_bottom;
    logic psr_active;

    // next state of everything
    always_comb begin
        next_st = st;
        mode = {st.control_reg_b[pos_wgm2], st.control_reg_a[1:0]};
        // top is max or compare a
        top = (mode == mode_ctc || mode[2]) ? st.compare_a_value : count_max;
        at_bottom = (st.counter_value == count_bottom);
        at_top = (st.counter_value == top);
        psr_active = st.prescaler_sync_reset;
        // writes land at the edge where the master sees waitrequest low
        wr = av_req.write && st.ack;
        rd = av_req.read && !st.ack;
        next_st.ack = (av_req.write || av_req.read) && !st.ack;
        next_st.rdata = 32'h0000_0000;

        // pin sync, first stage read only by second
        next_st.pin_sync = {st.pin_sync[0], external_count_pin};
        next_st.pin_last = st.pin_sync[1];

        // shared prescaler held or cleared by sync reset
        // both timers see the same restart
        if (psr_active) begin
            next_st.presc = '0;
        end else begin
            next_st.presc = st.presc + 1'b1;
        end

        tick = 1'b0;
        if (!st.timer_power_off) begin
            case (st.control_reg_b[2:0])
                3'h0: tick = 1'b0;
                3'h1: tick = 1'b1;
                3'h2: tick = !psr_active && (st.presc[2:0] == 3'h7);
                3'h3: tick = !psr_active && (st.presc[5:0] == 6'h3f);
                3'h4: tick = !psr_active && (st.presc[7:0] == 8'hff);
                3'h5: tick = !psr_active && (&st.presc);
                3'h6: tick = st.pin_last && !st.pin_sync[1];
                default: tick = !st.pin_last && st.pin_sync[1];
            endcase
        end

        match_a = (st.counter_value == st.compare_a_value) && !st.block_match;
        match_b = (st.counter_value == st.compare_b_value) && !st.block_match;

        if (tick) begin
            next_st.block_match = 1'b0;
            // flag set on the tick after equality
            if (match_a) next_st.flags[pos_cmp_a] = 1'b1;
            if (match_b) next_st.flags[pos_cmp_b] = 1'b1;
            if (match_a) begin
                next_st.oc_a = apply_action(st.control_reg_a[7:6], st.oc_a);
            end
            if (match_b) begin
                next_st.oc_b = apply_action(st.control_reg_a[5:4], st.oc_b);
            end
            if (mode == mode_pwm_phase || mode == mode_pwm_phase_a) begin
                if (at_top && !st.count_down) begin
                    next_st.count_down = 1'b1;
                    next_st.counter_value = st.counter_value - 8'h01;
                end else if (at_bottom && st.count_down) begin
                    next_st.count_down = 1'b0;
                    next_st.counter_value = st.counter_value + 8'h01;
                    next_st.flags[pos_ovf] = 1'b1;
                end else if (st.count_down) begin
                    next_st.counter_value = st.counter_value - 8'h01;
                end else begin
                    next_st.counter_value = st.counter_value + 8'h01;
                end
            end else if (at_top && mode != mode_normal) begin
                next_st.counter_value = count_bottom;
                if (mode != mode_ctc) next_st.flags[pos_ovf] = 1'b1;
            end else begin
                next_st.counter_value = st.counter_value + 8'h01;
                // overflow as the count wraps to zero
                if (st.counter_value == count_max) begin
                    next_st.flags[pos_ovf] = 1'b1;
                end
            end
            // buffers only move in pwm modes
            if (is_pwm(mode) && (at_top || at_bottom)) begin
                next_st.compare_a_value = st.compare_a_buf;
                next_st.compare_b_value = st.compare_b_buf;
            end
        end

        if (!st.sync_hold_mode) begin
            // self-clear when hold mode is off
            next_st.prescaler_sync_reset = 1'b0;
        end

        // register writes
        if (wr) begin
            case (av_req.address)
                addr_control_a: next_st.control_reg_a = av_req.writedata[7:0];
                addr_control_b: begin
                    next_st.control_reg_b = av_req.writedata[5:0];
                    if (!is_pwm({av_req.writedata[pos_wgm2],
                        st.control_reg_a[1:0]})) begin
                        if (av_req.writedata[pos_force_a]) begin
                            next_st.oc_a = apply_action(
                                st.control_reg_a[7:6], st.oc_a);
                        end
                        if (av_req.writedata[pos_force_b]) begin
                            next_st.oc_b = apply_action(
                                st.control_reg_a[5:4], st.oc_b);
                        end
                    end
                end
                addr_counter: begin
                    next_st.counter_value = av_req.writedata[7:0];
                    next_st.block_match = 1'b1;
                end
                addr_compare_a: begin
                    next_st.compare_a_buf = av_req.writedata[7:0];
                    if (!is_pwm(mode)) begin
                        next_st.compare_a_value = av_req.writedata[7:0];
                    end
                end
                addr_compare_b: begin
                    next_st.compare_b_buf = av_req.writedata[7:0];
                    if (!is_pwm(mode)) begin
                        next_st.compare_b_value = av_req.writedata[7:0];
                    end
                end
                addr_flags: begin
                    // write one clears, a set the same tick wins
                    next_st.flags = next_st.flags &
                        ~(av_req.writedata[2:0] & ~(next_st.flags ^ st.flags));
                end
                addr_mask: next_st.mask = av_req.writedata[2:0];
                addr_general: begin
                    next_st.sync_hold_mode = av_req.writedata[pos_sync_hold];
                    next_st.prescaler_sync_reset = av_req.writedata[pos_psr];
                end
                addr_power: next_st.timer_power_off = av_req.writedata[0];
                addr_service: begin
                    next_st.flags = next_st.flags &
                        ~(av_req.writedata[2:0] & ~(next_st.flags ^ st.flags));
                end
                default: ;
            endcase
        end

        // register reads
        if (rd) begin
            case (av_req.address)
                addr_control_a: next_st.rdata = {24'h0, st.control_reg_a};
                addr_control_b: next_st.rdata = {26'h0, st.control_reg_b};
                addr_counter: next_st.rdata = {24'h0, st.counter_value};
                addr_compare_a: next_st.rdata = {24'h0,
                    is_pwm(mode) ? st.compare_a_buf : st.compare_a_value};
                addr_compare_b: next_st.rdata = {24'h0,
                    is_pwm(mode) ? st.compare_b_buf : st.compare_b_value};
                addr_flags: next_st.rdata = {29'h0, st.flags};
                addr_mask: next_st.rdata = {29'h0, st.mask};
                addr_general: next_st.rdata = {24'h0, st.sync_hold_mode,
                    6'h00, st.prescaler_sync_reset};
                addr_power: next_st.rdata = {31'h0, st.timer_power_off};
                default: next_st.rdata = 32'h0000_0000;
            endcase
        end

        next_st.irq = next_st.flags & next_st.mask;
        next_st.psr_out = next_st.prescaler_sync_reset;
    end

    // one register for all state
    always_ff @(posedge clk) begin
        if (!rstn) begin
            st <= '0;
            st.timer_power_off <= power_off_reset;
        end else begin
            st <= next_st;
        end
    end

    // outputs straight from flip-flops
    assign av_readdata = st.rdata;
    // wait until the answer strobe
    assign av_waitrequest = !st.ack;
    assign compare_output_a = st.oc_a;
    assign compare_output_b = st.oc_b;
    assign irq_overflow = st.irq[pos_ovf];
    assign irq_compare_a = st.irq[pos_cmp_a];
    assign irq_compare_b = st.irq[pos_cmp_b];
    assign prescaler_clear = st.psr_out;
endmodule
`default_nettype wire

//--- hw/timer8_pkg.sv
package timer8_pkg;

    // register word addresses (byte address = 4 * index)
    localparam logic [3:0] addr_control_a = 4'h0;
    localparam logic [3:0] addr_control_b = 4'h1;
    localparam logic [3:0] addr_counter = 4'h2;
    localparam logic [3:0] addr_compare_a = 4'h3;
    localparam logic [3:0] addr_compare_b = 4'h4;
    localparam logic [3:0] addr_flags = 4'h5;
    localparam logic [3:0] addr_mask = 4'h6;
    localparam logic [3:0] addr_general = 4'h7;
    localparam logic [3:0] addr_power = 4'h8;
    localparam logic [3:0] addr_service = 4'h9;

    // field positions
    localparam int pos_com_a = 6;      // control_reg_a [7:6]
    localparam int pos_com_b = 4;      // control_reg_a [5:4]
    localparam int pos_force_a = 7;    // control_reg_b
    localparam int pos_force_b = 6;
    localparam int pos_wgm2 = 3;
    localparam int pos_sync_hold = 7;  // general_timer_control
    localparam int pos_psr = 0;
    localparam int pos_ovf = 0;        // flags and mask
    localparam int pos_cmp_a = 1;
    localparam int pos_cmp_b = 2;

    localparam logic [7:0] count_bottom = 8'h00;
    localparam logic [7:0] count_max = 8'hff;
    localparam logic [7:0] reset_byte = 8'h00;
    localparam logic power_off_reset = 1'b1;

    // prescaler taps
    localparam int presc_width = 10;

    // waveform modes
    typedef enum logic [2:0] {
        mode_normal = 3'h0,
        mode_pwm_phase = 3'h1,
        mode_ctc = 3'h2,
        mode_fast = 3'h3,
        mode_pwm_phase_a = 3'h5,
        mode_fast_a = 3'h7
    } wave_mode_e;

    // avalon request bundle
    typedef struct packed {
        logic [3:0] address;
        logic read;
        logic write;
        logic [31:0] writedata;
    } av_req_s;

endpackage

//--- bench/timer8_counter_compare_sva.sv
`timescale 1ns/100ps
`default_nettype none
module timer8_counter_compare_sva (
    input wire logic clk,
    input wire logic rstn,
    input wire timer8_pkg::av_req_s av_req,
    input wire logic [31:0] av_readdata,
    input wire logic av_waitrequest,
    input wire logic external_count_pin,
    input wire logic compare_output_a,
    input wire logic compare_output_b,
    input wire logic irq_overflow,
    input wire logic irq_compare_a,
    input wire logic irq_compare_b,
    input wire logic prescaler_clear
);
    import timer8_pkg::*;
    logic wr_ack; // write answered in this cycle
    logic gen_wr, ctl_wr, msk_wr; // write pending to a shadowed register
    logic [2:0] mask_h; // shadow of the mask register
    logic [3:0] act_h; // shadow of both output actions
    logic hold_h; // shadow of the sync hold bit
    assign wr_ack = av_req.write && !av_waitrequest;
    assign gen_wr = av_req.write && av_req.address == addr_general;
    assign ctl_wr = av_req.write && av_req.address == addr_control_a;
    assign msk_wr = av_req.write && av_req.address == addr_mask;
    // shadows load on the same edge as the design registers, pending writes are skipped below
    always_ff @(posedge clk) begin
        if (!rstn) begin
            mask_h <= 3'h0;
            act_h <= 4'h0;
            hold_h <= 1'b0;
        end else if (wr_ack) begin
            if (msk_wr) begin
                mask_h <= av_req.writedata[2:0];
            end
            if (ctl_wr) begin
                act_h <= av_req.writedata[7:4];
            end
            if (gen_wr) begin
                hold_h <= av_req.writedata[7];
            end
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    sequence s_answer;
        ##[1:2] !av_waitrequest;
    endsequence
    sequence s_pulse;
        ##[0:2] prescaler_clear;
    endsequence
    property p_req_answer;
        (av_req.read || av_req.write) && av_waitrequest |-> s_answer;
    endproperty
    a_req_answer: assert property (p_req_answer)
        else $error("request not answered in two cycles");
    property p_wait_one;
        !av_waitrequest |=> av_waitrequest;
    endproperty
    a_wait_one: assert property (p_wait_one)
        else $error("answer held longer than one cycle");
    property p_read_idle;
        av_waitrequest |-> av_readdata == 32'h0;
    endproperty
    a_read_idle: assert property (p_read_idle)
        else $error("read data not zero outside an answer");
    property p_read_width;
        !av_waitrequest && av_req.read |-> av_readdata[31:8] == 24'h0;
    endproperty
    a_read_width: assert property (p_read_width)
        else $error("upper read bits not zero");
    property p_psr_seen;
        wr_ack && gen_wr && av_req.writedata[0] |-> s_pulse;
    endproperty
    a_psr_seen: assert property (p_psr_seen)
        else $error("prescaler clear missing after write");
    property p_psr_pulse;
        prescaler_clear && !hold_h && !gen_wr |=> !prescaler_clear;
    endproperty
    a_psr_pulse: assert property (p_psr_pulse)
        else $error("prescaler clear not released by hardware");
    property p_hold_keep;
        prescaler_clear && hold_h && !gen_wr |=> prescaler_clear;
    endproperty
    a_hold_keep: assert property (p_hold_keep)
        else $error("prescaler clear dropped in hold mode");
    property p_keep_a;
        act_h[3:2] == 2'h0 && !ctl_wr |=> $stable(compare_output_a);
    endproperty
    a_keep_a: assert property (p_keep_a)
        else $error("output a moved with action zero");
    property p_keep_b;
        act_h[1:0] == 2'h0 && !ctl_wr |=> $stable(compare_output_b);
    endproperty
    a_keep_b: assert property (p_keep_b)
        else $error("output b moved with action zero");
    property p_irq_ovf;
        !mask_h[0] && !msk_wr |-> !irq_overflow;
    endproperty
    a_irq_ovf: assert property (p_irq_ovf)
        else $error("overflow request while masked");
    property p_irq_a;
        !mask_h[1] && !msk_wr |-> !irq_compare_a;
    endproperty
    a_irq_a: assert property (p_irq_a)
        else $error("compare a request while masked");
    property p_irq_b;
        !mask_h[2] && !msk_wr |-> !irq_compare_b;
    endproperty
    a_irq_b: assert property (p_irq_b)
        else $error("compare b request while masked");
endmodule
`default_nettype wire

//--- bench/timer8_counter_compare_tb.sv
`timescale 1ns/100ps
`default_nettype none
module timer8_counter_compare_tb;
    import timer8_pkg::*;
    // compare, count and report one value
    `define CHK(n, e, g) cmp_count++; \
        if ((g) !== (e)) begin \
            fail_count++; \
            $display("[ERR] %s exp %h got %h", n, e, g); \
        end
    logic clk = 1'b0;
    logic rstn = 1'b0;
    av_req_s av_req = '0;
    logic pin = 1'b0; // external count source
    logic [31:0] av_readdata, q;
    logic av_waitrequest, compare_output_a, compare_output_b;
    logic irq_overflow, irq_compare_a, irq_compare_b, prescaler_clear;
    logic [2:0] frc [5] = '{3'h7, 3'h1, 3'h4, 3'h3, 3'h2}; // action, out
    int fail_count = 0;
    int cmp_count = 0;
    int cycles = 0;
    always #12.5 clk = ~clk;
    timer8_counter_compare i_dut (.clk(clk), .rstn(rstn), .av_req(av_req),
        .av_readdata(av_readdata), .av_waitrequest(av_waitrequest),
        .external_count_pin(pin), .compare_output_a(compare_output_a),
        .compare_output_b(compare_output_b), .irq_overflow(irq_overflow),
        .irq_compare_a(irq_compare_a), .irq_compare_b(irq_compare_b),
        .prescaler_clear(prescaler_clear));
    // verdict and end of run
    task automatic close_out();
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // one transfer; waitrequest and read data are taken at a rising edge
    task automatic bus(input logic [3:0] a, input logic w,
        input logic [7:0] d);
        av_req.address <= a;
        av_req.write <= w;
        av_req.read <= !w;
        av_req.writedata <= {24'h0, d};
        do @(posedge clk); while (av_waitrequest !== 1'b0);
        q = av_readdata;
        av_req.read <= 1'b0;
        av_req.write <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        bus(a, 1'b1, d);
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e, string n);
        bus(a, 1'b0, 8'h00);
        `CHK(n, {24'h0, e}, q)
    endtask
    // run the counter n+3 cycles with clock select c, then stop it
    task automatic run(input logic [2:0] c, input int n);
        wr(addr_control_b, {5'h0, c});
        repeat (n) @(posedge clk);
        wr(addr_control_b, 8'h00);
    endtask
    // hang guard, well above the expected run length
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count++;
            close_out();
        end
    end
    initial begin
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        rd(addr_power, 8'h01, "power_rst");
        wr(addr_power, 8'h00);
        rd(addr_flags, 8'h00, "flags_rst");
        wr(4'hf, 8'h5a);
        rd(4'hf, 8'h00, "unmapped");
        wr(addr_counter, 8'ha5);
        repeat (20) @(posedge clk);
        rd(addr_counter, 8'ha5, "stopped");
        // external edges, falling then rising
        for (int c = 6; c < 8; c++) begin
            wr(addr_counter, 8'h00);
            wr(addr_control_b, c[7:0]);
            repeat (4) begin
                repeat (4) @(posedge clk);
                pin <= 1'b1;
                repeat (4) @(posedge clk);
                pin <= 1'b0;
            end
            repeat (6) @(posedge clk);
            wr(addr_control_b, 8'h00);
            rd(addr_counter, 8'h04, "pin_count");
        end
        wr(addr_mask, 8'h01);
        wr(addr_counter, 8'hf0);
        run(3'h1, 40);
        bus(addr_flags, 1'b0, 8'h00);
        `CHK("ovf_flag", 1'b1, q[0])
        `CHK("ovf_irq", 1'b1, irq_overflow)
        wr(addr_flags, 8'h07);
        rd(addr_flags, 8'h00, "w1c");
        wr(addr_compare_a, 8'h10);
        wr(addr_mask, 8'h02);
        wr(addr_counter, 8'h0c);
        run(3'h1, 12);
        bus(addr_flags, 1'b0, 8'h00);
        `CHK("match_a", 1'b1, q[1])
        `CHK("irq_a", 1'b1, irq_compare_a)
        wr(addr_service, 8'h02);
        rd(addr_flags, 8'h00, "serviced");
        wr(addr_counter, 8'h10);
        run(3'h1, 4);
        rd(addr_flags, 8'h00, "blocked");
        // normal mode runs past compare a, clear-on-match never passes it
        for (int m = 0; m < 2; m++) begin
            wr(addr_control_a, m ? 8'h02 : 8'h00);
            wr(addr_compare_a, 8'h05);
            wr(addr_counter, 8'h00);
            run(3'h1, 30);
            bus(addr_counter, 1'b0, 8'h00);
            `CHK("top", m ? 1'b1 : 1'b0, q[7:0] <= 8'h05)
        end
        wr(addr_control_a, 8'h00);
        wr(addr_flags, 8'h07);
        foreach (frc[k]) begin
            wr(addr_control_a, {frc[k][2:1], frc[k][2:1], 4'h0});
            wr(addr_control_b, 8'hc0);
            `CHK("force_a", frc[k][0], compare_output_a)
            `CHK("force_b", frc[k][0], compare_output_b)
        end
        rd(addr_flags, 8'h00, "force_flag");
        rd(addr_control_b, 8'h00, "force_rd");
        wr(addr_control_a, 8'hf3);
        wr(addr_control_b, 8'hc0);
        `CHK("pwm_force", 1'b0, compare_output_a)
        // old compare value 0x50 is never reached by either run
        wr(addr_control_a, 8'h00);
        wr(addr_compare_a, 8'h50);
        wr(addr_control_a, 8'h03);
        wr(addr_compare_a, 8'h22);
        wr(addr_counter, 8'h1e);
        wr(addr_flags, 8'h07);
        run(3'h1, 10);
        rd(addr_flags, 8'h00, "buffered");
        wr(addr_counter, 8'h80);
        run(3'h1, 170);
        bus(addr_flags, 1'b0, 8'h00);
        `CHK("loaded", 1'b1, q[1])
        wr(addr_control_a, 8'h00);
        wr(addr_general, 8'h01);
        rd(addr_general, 8'h00, "psr_self");
        wr(addr_general, 8'h81);
        rd(addr_general, 8'h81, "psr_hold");
        `CHK("psr_out", 1'b1, prescaler_clear)
        wr(addr_counter, 8'h00);
        for (int c = 2; c < 6; c++) begin
            run(c[2:0], 20);
        end
        rd(addr_counter, 8'h00, "psr_halt");
        wr(addr_general, 8'h00);
        close_out();
    end
endmodule
bind timer8_counter_compare timer8_counter_compare_sva i_sva (.clk(clk),
    .rstn(rstn), .av_req(av_req), .av_readdata(av_readdata),
    .av_waitrequest(av_waitrequest), .external_count_pin(external_count_pin),
    .compare_output_a(compare_output_a), .compare_output_b(compare_output_b),
    .irq_overflow(irq_overflow), .irq_compare_a(irq_compare_a),
    .irq_compare_b(irq_compare_b), .prescaler_clear(prescaler_clear));
`default_nettype wire
